//--- src/thermo_config_status.sv
// Configuration and status register with conversion and thermostat control
//
// Operation
// R1: Upper byte at ACh, lower at ADh
// R2: Nonvolatile bits restored at power-up
// R3: Done reads 0 while converting
// R4: NV busy shows EEPROM write in progress
// R5: High flag sticky on temp >= upper
// R6: Low flag sticky on temp <= lower
// R7: Resolution sets conversion time 25-200 ms
// R8: Auto-convert starts converting at power-up
// R9: Single mode: one conversion per command
// R10: Single plus auto: pin one triggers
// R11: Continuous conversions upon begin command
// R12: Continuous from power-up when auto set; code needs single clear too, else one conversion
// R13: Single bit alone never halts continuous
// R14: Output function 0 forces pin low
// R15: Polarity picks alarm type, else ignored
// R16: Bits 5:3 mirror address pins
// R17: Three user bits, no side effect
// R18: Pin updates after conversion or write
// R19: Alarm hysteresis between trip points
// R20: Writes leave read-only bits unchanged
`timescale 1ns/1ps
module thermo_config_status
  import thermo_cfg_pkg::*;
#(
  parameter int convBaseCycles = CONV_BASE_CYCLES
) (
  // Clock and reset
  input  wire logic               clock,
  input  wire logic               rst,
  // Byte register access from the serial engine
  input  wire logic [7:0]         regAddr,
  input  wire logic               regWrite,
  input  wire logic [7:0]         regWrData,
  output logic      [7:0]         regRdData,
  // Commands from the serial engine
  input  wire logic               startConvertCmd,
  input  wire logic               stopConvertCmd,
  // Nonvolatile image and EEPROM state
  input  wire logic [1:0]         nvResSel,
  input  wire logic               nvAutoConvert,
  input  wire logic               nvSingleMode,
  input  wire logic               nvPolarity,
  input  wire logic [2:0]         nvUserBits,
  input  wire logic               nvBusyIn,
  // Temperature and trip points
  input  wire logic signed [15:0] temperature,
  input  wire logic signed [15:0] upperTripPoint,
  input  wire logic signed [15:0] lowerTripPoint,
  input  wire logic               tempWritten,
  // Address select pins, asynchronous
  input  wire logic [2:0]         addrPinsIn,
  // Converter control and output pin
  output logic                    converting,
  output logic                    progOutputPinOe
);

  // ==========================================================================
  // Register state
  logic           doneFlag;
  logic           nvBusyFlag;
  logic           highLimitFlag;
  logic           lowLimitFlag;
  logic [1:0]     resSel;
  logic           autoConvertOnPower;
  logic           singleConversionMode;
  logic           outputFunctionSel;
  logic           outputPolaritySel;
  logic [2:0]     userBits;
  logic           loadPending;
  logic           continuous;
  logic           alarmActive;
  conv_state_type state;
  logic [31:0]    convCount;
  logic [2:0]     pinMeta;
  logic [2:0]     pinSync;
  logic [2:0]     pinLast;
  logic [2:0]     addrPins;

  // ==========================================================================
  // Conversion length per resolution
  function automatic logic [31:0] conv_limit(input logic [1:0] res);
    conv_limit = 32'(convBaseCycles) << res; // [R7]
  endfunction

  // ==========================================================================
  // Decoding
  wire        selHigh      = (regAddr == ADDR_CFG_HIGH); // [R1]
  wire        selLow       = (regAddr == ADDR_CFG_LOW);  // [R1]
  wire        writeHigh    = regWrite && selHigh;
  wire        writeLow     = regWrite && selLow;
  wire        convEnd      = (state == CONV_RUNNING) && (convCount == 32'h0000_0001);
  wire        tempUpdate   = tempWritten && (state == CONV_IDLE); // [R18]
  wire        compareNow   = convEnd || tempUpdate;
  wire        tempGeUpper  = (temperature >= upperTripPoint);
  wire        tempLeLower  = (temperature <= lowerTripPoint);
  wire        pinOneRise   = (pinSync[1] == pinLast[1]) && pinLast[1] && !addrPins[1];
  wire        pinTrigger   = autoConvertOnPower && singleConversionMode && pinOneRise; // [R10]
  wire        cmdStart     = startConvertCmd && !continuous;
  wire        beginConv    = (state == CONV_IDLE) && (cmdStart || pinTrigger);
  wire        powerStart   = loadPending && nvAutoConvert; // [R8] [R12]
  wire [15:0] fullReg      = {doneFlag, nvBusyFlag, highLimitFlag, lowLimitFlag, resSel,
                              autoConvertOnPower, singleConversionMode, outputFunctionSel,
                              outputPolaritySel, addrPins, userBits};
  wire [7:0]  next_rdData  = selHigh ? fullReg[15:8] : (selLow ? fullReg[7:0] : 8'h00);

  // Alarm decision in the selected mode
  wire highAlarmOutputMode = outputPolaritySel;
  wire next_alarm = highAlarmOutputMode ?
                    (tempGeUpper ? 1'b1 : (tempLeLower ? 1'b0 : alarmActive)) :
                    (tempLeLower ? 1'b1 : (tempGeUpper ? 1'b0 : alarmActive)); // [R15] [R19]

  // ==========================================================================
  // Address pins: three stages, change taken when stages two and three agree
  always_ff @(posedge clock) begin
    if (rst) begin
      pinMeta  <= 3'h0;
      pinSync  <= 3'h0;
      pinLast  <= 3'h0;
      addrPins <= 3'h0;
    end else begin
      pinMeta <= addrPinsIn;
      pinSync <= pinMeta;
      pinLast <= pinSync;
      if (pinSync == pinLast) begin
        addrPins <= pinLast; // [R16]
      end
    end
  end

  // ==========================================================================
  // Conversion controller
  always_ff @(posedge clock) begin
    if (rst) begin
      state      <= CONV_IDLE;
      continuous <= 1'b0;
      convCount  <= 32'h0000_0000;
    end else if (powerStart) begin
      state      <= CONV_RUNNING;                  // [R8]
      continuous <= !nvSingleMode;                 // [R12]
      convCount  <= conv_limit(nvResSel);
    end else if (stopConvertCmd) begin
      state      <= CONV_IDLE;                     // [R13]
      continuous <= 1'b0;
    end else if (beginConv) begin
      state      <= CONV_RUNNING;
      continuous <= !singleConversionMode;         // [R9] [R11]
      convCount  <= conv_limit(resSel);            // [R7]
    end else if (convEnd) begin
      state      <= continuous ? CONV_RUNNING : CONV_IDLE; // [R9] [R13]
      convCount  <= conv_limit(resSel);
    end else if (state == CONV_RUNNING) begin
      convCount  <= convCount - 32'h0000_0001;
    end
  end

  // ==========================================================================
  // Status bits and power-up restore
  always_ff @(posedge clock) begin
    if (rst) begin
      loadPending   <= 1'b1;
      doneFlag      <= RST_DONE;
      nvBusyFlag    <= RST_NV_BUSY;
      highLimitFlag <= RST_HIGH_FLAG;
      lowLimitFlag  <= RST_LOW_FLAG;
    end else begin
      loadPending <= 1'b0;
      nvBusyFlag  <= nvBusyIn;                       // [R4]
      doneFlag    <= !(powerStart || beginConv || (convEnd && continuous)) &&
                     (doneFlag || convEnd);          // [R3]
      if (compareNow && tempGeUpper) begin
        highLimitFlag <= 1'b1;                       // [R5]
      end else if (writeHigh) begin
        highLimitFlag <= highLimitFlag && regWrData[BIT_HIGH_FLAG-8];
      end
      if (compareNow && tempLeLower) begin
        lowLimitFlag <= 1'b1;                        // [R6]
      end else if (writeHigh) begin
        lowLimitFlag <= lowLimitFlag && regWrData[BIT_LOW_FLAG-8];
      end
    end
  end

  // ==========================================================================
  // Writable configuration bits
  always_ff @(posedge clock) begin
    if (rst) begin
      resSel               <= 2'h0;
      autoConvertOnPower   <= 1'b0;
      singleConversionMode <= 1'b0;
      outputFunctionSel    <= RST_OUT_FUNC;          // [R14]
      outputPolaritySel    <= 1'b0;
      userBits             <= 3'h0;
    end else if (loadPending) begin
      resSel               <= nvResSel;              // [R2]
      autoConvertOnPower   <= nvAutoConvert;
      singleConversionMode <= nvSingleMode;
      outputPolaritySel    <= nvPolarity;
      userBits             <= nvUserBits;
    end else begin
      if (writeHigh) begin
        resSel               <= regWrData[BIT_RES_HI-8:BIT_RES_LO-8]; // [R20]
        autoConvertOnPower   <= regWrData[BIT_AUTO_CONV-8];
        singleConversionMode <= regWrData[BIT_SINGLE-8];
      end
      if (writeLow) begin
        outputFunctionSel <= regWrData[BIT_OUT_FUNC];
        outputPolaritySel <= regWrData[BIT_OUT_POL];
        userBits          <= regWrData[BIT_USER_TOP:0]; // [R17] [R20]
      end
    end
  end

  // ==========================================================================
  // Thermostat output and registered outputs
  always_ff @(posedge clock) begin
    if (rst) begin
      alarmActive     <= 1'b0;
      progOutputPinOe <= 1'b0;
      converting      <= 1'b0;
      regRdData       <= 8'h00;
    end else begin
      if (compareNow) begin
        alarmActive <= next_alarm;                   // [R18]
      end
      progOutputPinOe <= !outputFunctionSel || alarmActive; // [R14]
      converting      <= (state == CONV_RUNNING);
      regRdData       <= next_rdData;                // [R1]
    end
  end

  // ==========================================================================
  // Checks
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  done_while_conv_a: assert property ((state == CONV_RUNNING) && ($past(state) == CONV_RUNNING) // [R3]
                                      && !$past(convEnd) |-> !doneFlag)
    else $error("done set during conversion");
  nv_busy_copy_a: assert property (nvBusyIn |=> nvBusyFlag) // [R4]
    else $error("nv busy not shown");
  high_flag_set_a: assert property (compareNow && tempGeUpper |=> highLimitFlag) // [R5]
    else $error("high flag not set");
  low_flag_set_a: assert property (compareNow && tempLeLower |=> lowLimitFlag) // [R6]
    else $error("low flag not set");
  conv_length_a: assert property (beginConv && !powerStart && !stopConvertCmd // [R7]
                                  |=> convCount == conv_limit($past(resSel)))
    else $error("wrong conversion length");
  auto_power_a: assert property (powerStart |=> state == CONV_RUNNING ##1 !doneFlag) // [R8]
    else $error("no power-up conversion");
  single_stop_a: assert property (convEnd && !continuous && !stopConvertCmd && !powerStart // [R9]
                                  |=> (state == CONV_IDLE) && doneFlag)
    else $error("single conversion did not stop");
  force_low_a: assert property (!outputFunctionSel |=> progOutputPinOe) // [R14]
    else $error("output not forced low");
  addr_copy_a: assert property (selLow |=> regRdData[BIT_ADDR_TOP:BIT_ADDR_BOT] == $past(addrPins)) // [R16]
    else $error("address bits not mirrored");
  ro_write_a: assert property (writeHigh && !compareNow && !nvBusyIn // [R20]
                               |=> !nvBusyFlag)
    else $error("read-only bit written");

  // Mode, thermostat, write, restore and read checks
  pin_trigger_a: assert property (pinTrigger && (state == CONV_IDLE) && !powerStart && !stopConvertCmd // [R10]
                                  |=> state == CONV_RUNNING)
    else $error("pin trigger ignored");
  cont_restart_a: assert property (convEnd && continuous && !stopConvertCmd && !powerStart // [R11]
                                   |=> state == CONV_RUNNING)
    else $error("continuous conversion stopped");
  power_mode_a: assert property (powerStart |=> continuous == !$past(nvSingleMode)) // [R12]
    else $error("wrong power-up mode");
  no_halt_a: assert property ((state == CONV_RUNNING) && continuous && !stopConvertCmd && !powerStart // [R13]
                              |=> (state == CONV_RUNNING) && continuous)
    else $error("continuous halted without stop");
  stop_halt_a: assert property (stopConvertCmd && !powerStart |=> (state == CONV_IDLE) && !continuous) // [R13]
    else $error("stop command ignored");
  thermo_pin_a: assert property (outputFunctionSel |=> progOutputPinOe == $past(alarmActive)) // [R14] [R15]
    else $error("output does not follow alarm");
  high_alarm_a: assert property (compareNow && outputPolaritySel && tempGeUpper |=> alarmActive) // [R18] [R19]
    else $error("high alarm not raised");
  low_alarm_a: assert property (compareNow && !outputPolaritySel && tempLeLower |=> alarmActive) // [R15] [R19]
    else $error("low alarm not raised");
  alarm_hold_a: assert property (compareNow && !tempGeUpper && !tempLeLower |=> $stable(alarmActive)) // [R19]
    else $error("alarm moved between trip points");
  alarm_quiet_a: assert property (!compareNow |=> $stable(alarmActive)) // [R18]
    else $error("alarm moved without update");
  flag_clear_a: assert property (writeHigh && !regWrData[BIT_HIGH_FLAG-8] && !(compareNow && tempGeUpper) // [R5]
                                 |=> !highLimitFlag)
    else $error("high flag not cleared");
  res_write_a: assert property (writeHigh && !loadPending // [R7] [R20]
                                |=> resSel == $past(regWrData[BIT_RES_HI-8:BIT_RES_LO-8]))
    else $error("resolution not written");
  user_write_a: assert property (writeLow && !loadPending // [R17]
                                 |=> userBits == $past(regWrData[BIT_USER_TOP:0]))
    else $error("user bits not written");
  nv_restore_a: assert property (loadPending // [R2]
                                 |=> resSel == $past(nvResSel) && userBits == $past(nvUserBits)
                                     && outputPolaritySel == $past(nvPolarity))
    else $error("nonvolatile bits not restored");
  read_other_a: assert property (!selHigh && !selLow |=> regRdData == 8'h00) // [R1]
    else $error("unmapped address read nonzero");

endmodule // thermo_config_status

//--- src/thermo_cfg_pkg.sv
// Constants for the thermometer configuration and status register
package thermo_cfg_pkg;

  // ==========================================================================
  // Byte locations in the memory map
  localparam logic [7:0] ADDR_CFG_HIGH = 8'h00ac;
  localparam logic [7:0] ADDR_CFG_LOW  = 8'h00ad;

  // ==========================================================================
  // Bit positions inside the 16-bit register
  localparam int BIT_DONE      = 15;
  localparam int BIT_NV_BUSY   = 14;
  localparam int BIT_HIGH_FLAG = 13;
  localparam int BIT_LOW_FLAG  = 12;
  localparam int BIT_RES_HI    = 11;
  localparam int BIT_RES_LO    = 10;
  localparam int BIT_AUTO_CONV = 9;
  localparam int BIT_SINGLE    = 8;
  localparam int BIT_OUT_FUNC  = 7;
  localparam int BIT_OUT_POL   = 6;
  localparam int BIT_ADDR_TOP  = 5;
  localparam int BIT_ADDR_BOT  = 3;
  localparam int BIT_USER_TOP  = 2;

  // ==========================================================================
  // Fixed power-up values of the volatile bits
  localparam logic RST_NV_BUSY   = 1'b0;
  localparam logic RST_HIGH_FLAG = 1'b0;
  localparam logic RST_LOW_FLAG  = 1'b0;
  localparam logic RST_OUT_FUNC  = 1'b1;
  localparam logic RST_DONE      = 1'b1;

  // ==========================================================================
  // Timing
  localparam int CLOCK_KHZ       = 125_000;
  localparam int CONV_BASE_MS    = 25;
  localparam int CONV_BASE_CYCLES = CONV_BASE_MS * CLOCK_KHZ;

  // ==========================================================================
  // Conversion controller states
  typedef enum logic [0:0] {
    CONV_IDLE    = 1'b0,
    CONV_RUNNING = 1'b1
  } conv_state_type;

endpackage

//--- testbench/serial_master_model.sv
// Model of the serial engine that reaches the register bytes
`timescale 1ns/1ps
module serial_master_model (
  // Clock
  input  wire logic       clock,
  // Register byte port
  output logic      [7:0] regAddr,
  output logic            regWrite,
  output logic      [7:0] regWrData,
  input  wire logic [7:0] regRdData
);
  initial begin
    regAddr   = 8'h00;
    regWrite  = 1'b0;
    regWrData = 8'h00;
  end
  // One-cycle write strobe; data scrambled once released
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock) #1;
    regAddr   = a;
    regWrite  = 1'b1;
    regWrData = d;
    @(posedge clock) #1;
    regWrite  = 1'b0;
    regWrData = ~d;
  endtask
  // Address held one cycle, registered answer taken after that edge
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock) #1;
    regAddr = a;
    @(posedge clock) #1;
    d = regRdData;
  endtask
endmodule // serial_master_model

//--- testbench/tb.sv
// Self-checking bench for the configuration and status register
`timescale 1ns/1ps
module tb;
  import thermo_cfg_pkg::*;
  localparam int BASE = 20;
  logic clock, rst, startConvertCmd, stopConvertCmd, nvAutoConvert, nvSingleMode, nvPolarity, nvBusyIn;
  logic tempWritten, regWrite, converting, progOutputPinOe;
  logic [7:0] regAddr, regWrData, regRdData, h, l;
  logic [1:0] nvResSel;
  logic [2:0] nvUserBits, addrPinsIn;
  logic signed [15:0] temperature, upperTripPoint, lowerTripPoint;
  logic [15:0] cfg, d;
  int miscompares, total_checks, n;
  // ==========
  // Clock, design and register master
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  thermo_config_status #(.convBaseCycles(BASE)) dut (.clock(clock), .rst(rst), .regAddr(regAddr),
    .regWrite(regWrite), .regWrData(regWrData), .regRdData(regRdData), .startConvertCmd(startConvertCmd),
    .stopConvertCmd(stopConvertCmd), .nvResSel(nvResSel), .nvAutoConvert(nvAutoConvert),
    .nvSingleMode(nvSingleMode), .nvPolarity(nvPolarity), .nvUserBits(nvUserBits), .nvBusyIn(nvBusyIn),
    .temperature(temperature), .upperTripPoint(upperTripPoint), .lowerTripPoint(lowerTripPoint),
    .tempWritten(tempWritten), .addrPinsIn(addrPinsIn), .converting(converting),
    .progOutputPinOe(progOutputPinOe));
  serial_master_model bus (.clock(clock), .regAddr(regAddr), .regWrite(regWrite), .regWrData(regWrData),
    .regRdData(regRdData));
  // ==========
  // Helpers
  task automatic tick(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic readCfg();
    bus.rd(ADDR_CFG_HIGH, h);
    bus.rd(ADDR_CFG_LOW, l);
    cfg = {h, l};
  endtask
  task automatic pulse(input int which);
    if (which == 0) startConvertCmd = 1'b1; else if (which == 1) stopConvertCmd = 1'b1; else tempWritten = 1'b1;
    tick(1);
    {startConvertCmd, stopConvertCmd, tempWritten} = 3'b000;
  endtask
  task automatic tempStep(input logic signed [15:0] v);
    temperature = v;
    pulse(2);
    tick(3);
  endtask
  task automatic waitConv(input logic lvl, input int lim);
    n = 0;
    while (converting !== lvl && n < lim) begin
      tick(1);
      n++;
    end
    chk(16'(converting), 16'(lvl));
  endtask
  task automatic doReset(input logic a, input logic s);
    {nvResSel, nvPolarity, nvUserBits} = 6'($urandom);
    {nvAutoConvert, nvSingleMode} = {a, s};
    rst = 1'b1;
    tick(2);
    rst = 1'b0;
    tick(3);
  endtask
  function automatic logic [15:0] cfgLow(input logic [15:0] v);
    return {8'h00, v[7:6], addrPinsIn, v[2:0]};
  endfunction
  task automatic give_verdict();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  initial begin
    #400_000;
    miscompares++;
    give_verdict();
  end
  // ==========
  // Tests
  initial begin
    {startConvertCmd, stopConvertCmd, tempWritten, nvBusyIn, addrPinsIn, rst} = 8'h01;
    {temperature, upperTripPoint, lowerTripPoint} = '0;
    void'($urandom(13201));
    doReset(1'b0, 1'($urandom));
    readCfg();
    d = {4'h8, nvResSel, 1'b0, nvSingleMode, 8'h80} | cfgLow({9'h000, nvPolarity, 3'h0, nvUserBits});
    chk(cfg, d);
    bus.rd(8'hab, h);
    chk(16'(h), 16'h0000);
    $display("test powerup finished");
    for (int i = 0; i < 8; i++) begin
      d = 16'($urandom);
      if (d[9]) d[8] = 1'b0; // Keep the pin trigger off while pins move
      {nvBusyIn, addrPinsIn} = 4'($urandom);
      bus.wr(ADDR_CFG_HIGH, d[15:8]);
      bus.wr(ADDR_CFG_LOW, d[7:0]);
      readCfg();
      chk(cfg, {1'b1, nvBusyIn, 2'b00, d[11:8], 8'h00} | cfgLow(d));
    end
    $display("test writes finished");
    nvBusyIn = 1'b0;
    for (int r = 0; r < 4; r++) begin
      temperature = 16'($urandom);
      if (temperature == 16'sh8000) temperature = 16'sh0000; // Lower trip would wrap
      upperTripPoint = temperature;
      lowerTripPoint = temperature - 16'sd1;
      bus.wr(ADDR_CFG_HIGH, {4'h0, 2'(r), 2'b01});
      bus.wr(ADDR_CFG_LOW, 8'hc0);
      pulse(0);
      waitConv(1'b1, 10);
      n = 0;
      while (converting === 1'b1 && n < 1000) begin
        tick(1);
        n++;
      end
      chk(16'(n), 16'(BASE << r));
      tick(2);
      readCfg();
      chk(16'(cfg[15:12]), 16'h000a);
      chk(16'(progOutputPinOe), 16'h0001);
    end
    bus.wr(ADDR_CFG_HIGH, 8'h31);
    readCfg();
    chk(16'(cfg[13:12]), 16'h0002);
    temperature = lowerTripPoint + 16'sd1;
    pulse(2);
    tick(3);
    chk(16'(progOutputPinOe), 16'h0001);
    temperature = lowerTripPoint;
    pulse(2);
    tick(3);
    chk(16'(progOutputPinOe), 16'h0000);
    bus.wr(ADDR_CFG_LOW, 8'h40);
    tick(2);
    chk(16'(progOutputPinOe), 16'h0001);
    upperTripPoint = 16'sd100;
    lowerTripPoint = -16'sd100;
    bus.wr(ADDR_CFG_LOW, 8'h80);
    tempStep(16'sd0);
    chk(16'(progOutputPinOe), 16'h0000);
    tempStep(-16'sd100);
    chk(16'(progOutputPinOe), 16'h0001);
    tempStep(16'sd0);
    chk(16'(progOutputPinOe), 16'h0001);
    tempStep(16'sd100);
    chk(16'(progOutputPinOe), 16'h0000);
    temperature = lowerTripPoint;
    $display("test single and output finished");
    bus.wr(ADDR_CFG_HIGH, 8'h00);
    pulse(0);
    waitConv(1'b1, 10);
    bus.wr(ADDR_CFG_HIGH, 8'h01);
    n = 0;
    for (int k = 0; k < 3 * BASE; k++) begin
      tick(1);
      n += 32'(converting === 1'b1);
    end
    chk(16'(n >= 2 * BASE), 16'h0001);
    pulse(1);
    tick(2);
    chk(16'(converting), 16'h0000);
    readCfg();
    chk(16'(cfg[12]), 16'h0001);
    $display("test continuous finished");
    doReset(1'b1, 1'b0);
    chk(16'(converting), 16'h0001);
    readCfg();
    chk(16'(cfg[15]), 16'h0000);
    addrPinsIn[1] = 1'b0;
    doReset(1'b1, 1'b1);
    waitConv(1'b1, 5);
    waitConv(1'b0, 200);
    tick(4);
    addrPinsIn[1] = 1'b1;
    waitConv(1'b1, 10);
    $display("test powerup modes finished");
    give_verdict();
  end
endmodule // tb
